// ### logic/cpu_regfile_consts.vh
// Constants for the core register file
`ifndef CPU_REGFILE_CONSTS_VH
`define CPU_REGFILE_CONSTS_VH

`define RF_IDX_PC          4'h0
`define RF_IDX_SP          4'h1
`define RF_IDX_SW          4'h2
`define RF_IDX_CG          4'h3
`define RF_FIRST_GP        4'h4

`define SW_BIT_C           0
`define SW_BIT_Z           1
`define SW_BIT_N           2
`define SW_BIT_GIE         3
`define SW_BIT_HALT        4
`define SW_BIT_LFOFF       5
`define SW_BIT_BIAS        6
`define SW_BIT_SUBGATE     7
`define SW_BIT_V           8
`define SW_USED_MASK       16'h01FF

`define MODE_REG           2'b00
`define MODE_IDX           2'b01
`define MODE_IND           2'b10
`define MODE_INC           2'b11

`define CONST_ZERO         16'h0000
`define CONST_ONE          16'h0001
`define CONST_TWO          16'h0002
`define CONST_FOUR         16'h0004
`define CONST_EIGHT        16'h0008
`define CONST_ALL_ONES     16'hFFFF
`define WORD_STEP          16'h0002
`define EVEN_MASK          16'hFFFE
`define LOW_BYTE_MASK      16'h00FF

`define RF_RESET_VALUE     16'h0000

`endif

// ### logic/cpu_register_file.v
// Core register file: sixteen 16-bit registers with constant generators
`default_nettype none
`include "cpu_regfile_consts.vh"

////////////////////////////////////////////////////////////////////////////
// Contract
// - Sixteen 16-bit registers; 0-3 dedicated, 4-15 general purpose.
// - Program counter advances by instruction length of two, four or six.
// - Program counter holds only even addresses; bit 0 reads zero.
// - Program counter is an operand; writing it branches.
// - Stack pointer predecrements on push, postincrements on pop.
// - Stack pointer even; software initialises it before stack use.
// - Pushing the stack pointer stores its old value, then decrements.
// - Popping the stack pointer loads popped word, skips increment.
// - Register 2 is status only in register mode with word size.
// - Overflow flag set on signed overflow of add or subtract.
// - Subsystem clock stops while submain clock gate bit set.
// - Oscillator bias off bit stops dc generator unless oscillator in use.
// - Crystal off bit disables crystal unless it sources a clock.
// - Core halt bit stops instruction execution.
// - Global interrupt enable passes or blocks maskable interrupts.
// - Negative flag copies bit 15 for words, bit 7 for bytes.
// - Zero flag set when result is zero.
// - Carry flag set on carry out.
// - Register 2 source modes 01,10,11 give zero, four, eight.
// - Register 3 source modes give zero, one, two, all ones.
// - Constant registers are source only and need no extra fetch.
// - Registers 4-15 accept byte and word accesses.
// - Byte writes clear the upper eight bits.
// - Interrupt entry clears core halt, clock gate and crystal off bits.
module cpu_register_file (
  input  wire        i_clk,
  input  wire        i_srst,
  // Source read port
  input  wire [3:0]  i_src_sel,
  input  wire [1:0]  i_source_mode_bits,
  input  wire        i_src_byte,
  output wire [15:0] o_src_data,
  output wire        o_src_is_const,
  // Second plain read port (destination operand / pointer)
  input  wire [3:0]  i_dst_sel,
  output wire [15:0] o_dst_data,
  // Destination write port
  input  wire        i_wr_en,
  input  wire [3:0]  i_wr_sel,
  input  wire        i_wr_byte,
  input  wire [15:0] i_wr_data,
  // Program counter advance
  input  wire        i_pc_adv,
  input  wire [1:0]  i_pc_words,
  // Stack operations
  input  wire        i_push,
  input  wire        i_pop,
  input  wire [15:0] i_pop_data,
  input  wire        i_pop_to_sp,
  // Flag update from the execution unit
  input  wire        i_flag_upd,
  input  wire        i_flag_byte,
  input  wire        i_flag_is_sub,
  input  wire        i_flag_has_v,
  input  wire [15:0] i_op_a,
  input  wire [15:0] i_op_b,
  input  wire [15:0] i_result,
  input  wire        i_carry_out,
  // Interrupt entry
  input  wire        i_irq_entry,
  // Clock source status
  input  wire        i_dco_in_use,
  input  wire        i_lfxt_in_use,
  // Outputs
  output reg  [15:0] o_program_counter,
  output reg  [15:0] o_stack_pointer,
  output reg  [15:0] o_status_word,
  output reg  [15:0] o_push_addr,
  output reg         o_global_irq_enable,
  output reg         o_core_halt,
  output reg         o_subsystem_clock_stop,
  output reg         o_osc_bias_off,
  output reg         o_lf_crystal_off
);

////////////////////////////////////////////////////////////////////////////
// Functions

  function [15:0] byte_fix;
    input [15:0] val;
    input        is_byte;
    begin
      byte_fix = is_byte ? (val & `LOW_BYTE_MASK) : val;
    end
  endfunction

  function [15:0] const_gen;
    input [3:0] sel;
    input [1:0] mode;
    begin
      const_gen = `CONST_ZERO;
      if (sel == `RF_IDX_SW) begin
        case (mode)
          `MODE_IDX: const_gen = `CONST_ZERO;
          `MODE_IND: const_gen = `CONST_FOUR;
          `MODE_INC: const_gen = `CONST_EIGHT;
          default:   const_gen = `CONST_ZERO;
        endcase
      end else begin
        case (mode)
          `MODE_REG: const_gen = `CONST_ZERO;
          `MODE_IDX: const_gen = `CONST_ONE;
          `MODE_IND: const_gen = `CONST_TWO;
          default:   const_gen = `CONST_ALL_ONES;
        endcase
      end
    end
  endfunction

////////////////////////////////////////////////////////////////////////////
// Storage

  reg [15:0] regs_q [0:15];
  reg [15:0] pc_d;
  reg [15:0] sp_d;
  reg [15:0] sw_d;
  reg        flag_v;
  reg        msb_a;
  reg        msb_b;
  reg        msb_r;
  reg [15:0] wval;
  integer    k;

////////////////////////////////////////////////////////////////////////////
// Reads

  // Status register shows as itself only for word register mode
  wire sw_as_reg = (i_source_mode_bits == `MODE_REG) && !i_src_byte;
  wire src_const = (i_src_sel == `RF_IDX_CG) ||
                   ((i_src_sel == `RF_IDX_SW) && !sw_as_reg);
  assign o_src_is_const = src_const;
  assign o_src_data = src_const
                    ? const_gen(i_src_sel, i_source_mode_bits)
                    : byte_fix(regs_q[i_src_sel], i_src_byte);
  assign o_dst_data = regs_q[i_dst_sel];

////////////////////////////////////////////////////////////////////////////
// Next-state for dedicated registers

  always @* begin
    wval = byte_fix(i_wr_data, i_wr_byte);
    pc_d = regs_q[`RF_IDX_PC];
    if (i_pc_adv)
      pc_d = pc_d + {13'h0000, i_pc_words, 1'b0};
    if (i_wr_en && i_wr_sel == `RF_IDX_PC)
      pc_d = wval;
    pc_d = pc_d & `EVEN_MASK;

    // Push decrements the pointer by two; software seeds it
    sp_d = regs_q[`RF_IDX_SP];
    if (i_push)
      sp_d = sp_d - `WORD_STEP;
    else if (i_pop)
      sp_d = i_pop_to_sp ? i_pop_data : sp_d + `WORD_STEP;
    if (i_wr_en && i_wr_sel == `RF_IDX_SP)
      sp_d = wval;
    sp_d = sp_d & `EVEN_MASK;

    sw_d = regs_q[`RF_IDX_SW];
    if (i_wr_en && i_wr_sel == `RF_IDX_SW)
      sw_d = wval & `SW_USED_MASK;
    msb_a = i_flag_byte ? i_op_a[7] : i_op_a[15];
    msb_b = i_flag_byte ? i_op_b[7] : i_op_b[15];
    msb_r = i_flag_byte ? i_result[7] : i_result[15];
    if (i_flag_is_sub)
      flag_v = (msb_a != msb_b) && (msb_r != msb_a);
    else
      flag_v = (msb_a == msb_b) && (msb_r != msb_a);
    if (i_flag_upd) begin
      sw_d[`SW_BIT_N] = msb_r;
      sw_d[`SW_BIT_Z] = (byte_fix(i_result, i_flag_byte)
                         == `CONST_ZERO);
      sw_d[`SW_BIT_C] = i_carry_out;
      sw_d[`SW_BIT_V] = i_flag_has_v & flag_v;
    end
    // Saved word is pushed first, so clearing here is after the save
    if (i_irq_entry) begin
      sw_d[`SW_BIT_HALT]    = 1'b0;
      sw_d[`SW_BIT_SUBGATE] = 1'b0;
      sw_d[`SW_BIT_LFOFF]   = 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////
// Register update

  always @(posedge i_clk) begin
    if (i_srst) begin
      for (k = 0; k < 16; k = k + 1) begin
        regs_q[k] <= `RF_RESET_VALUE;
      end
    end else begin
      regs_q[`RF_IDX_PC] <= pc_d;
      regs_q[`RF_IDX_SP] <= sp_d;
      regs_q[`RF_IDX_SW] <= sw_d;
      // Constant register 3 is never written
      if (i_wr_en && i_wr_sel >= `RF_FIRST_GP)
        regs_q[i_wr_sel] <= wval;
    end
  end

////////////////////////////////////////////////////////////////////////////
// Registered outputs

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_program_counter      <= `RF_RESET_VALUE;
      o_stack_pointer        <= `RF_RESET_VALUE;
      o_status_word          <= `RF_RESET_VALUE;
      o_push_addr            <= `RF_RESET_VALUE;
      o_global_irq_enable    <= 1'b0;
      o_core_halt            <= 1'b0;
      o_subsystem_clock_stop <= 1'b0;
      o_osc_bias_off         <= 1'b0;
      o_lf_crystal_off       <= 1'b0;
    end else begin
      o_program_counter      <= pc_d;
      o_stack_pointer        <= sp_d;
      o_status_word          <= sw_d;
      o_push_addr            <= sp_d - `WORD_STEP;
      o_global_irq_enable    <= sw_d[`SW_BIT_GIE];
      o_core_halt            <= sw_d[`SW_BIT_HALT];
      o_subsystem_clock_stop <= sw_d[`SW_BIT_SUBGATE];
      o_osc_bias_off         <= sw_d[`SW_BIT_BIAS] & !i_dco_in_use;
      o_lf_crystal_off       <= sw_d[`SW_BIT_LFOFF] & !i_lfxt_in_use;
    end
  end

endmodule // cpu_register_file
`default_nettype wire

// ### tb/exec_unit_model.sv
// Execution unit model that feeds results and carry to the flag port
`default_nettype none
module exec_unit_model (
  input  wire logic        i_byte,
  input  wire logic        i_sub,
  input  wire logic [15:0] i_a,
  input  wire logic [15:0] i_b,
  output logic      [15:0] o_res,
  output logic             o_carry
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] sum;
  // Subtract as a + ~b + 1, so carry means no borrow
  always_comb begin
    sum = {1'b0, i_a} + {1'b0, i_sub ? ~i_b : i_b} + {16'h0000, i_sub};
    o_carry = sum[16];
    o_res = sum[15:0];
    if (i_byte) begin
      sum = {9'h000, i_a[7:0]} + {9'h000, i_sub ? ~i_b[7:0] : i_b[7:0]}
          + {16'h0000, i_sub};
      o_carry = sum[8];
      o_res = {8'h00, sum[7:0]};
    end
  end
endmodule // exec_unit_model
`default_nettype wire

// ### tb/cpu_register_file_props.sv
// Port checks for the core register file
`default_nettype none
module cpu_register_file_props (
  input wire i_clk, i_srst, i_src_byte, i_wr_en, i_pc_adv, i_push, i_pop,
  input wire i_pop_to_sp, i_flag_upd, i_flag_byte, i_irq_entry,
  input wire o_src_is_const, o_core_halt, o_subsystem_clock_stop,
  input wire [3:0] i_src_sel, i_wr_sel,
  input wire [1:0] i_source_mode_bits, i_pc_words,
  input wire [15:0] i_pop_data, i_result, o_src_data,
  input wire [15:0] o_program_counter, o_stack_pointer, o_status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire sp_wr = i_wr_en && i_wr_sel == 4'h1;
  wire pc_wr = i_wr_en && i_wr_sel == 4'h0;
  wire n_bit = i_flag_byte ? i_result[7] : i_result[15];
  wire [1:0] m = i_source_mode_bits;
  sequence push_req; i_push && !sp_wr; endsequence
  sequence pop_sp_req; i_pop && i_pop_to_sp && !i_push && !sp_wr; endsequence
  ptr_even_a: assert property (
    !o_program_counter[0] && !o_stack_pointer[0]) else $error("odd ptr");
  pc_step_a: assert property (i_pc_adv && !pc_wr |=> o_program_counter ==
    $past(o_program_counter) + {$past(i_pc_words), 1'b0}) else $error("pc");
  push_dec_a: assert property (push_req |=>
    o_stack_pointer == $past(o_stack_pointer) - 16'h0002) else $error("push");
  pop_load_a: assert property (pop_sp_req |=>
    o_stack_pointer == ($past(i_pop_data) & 16'hFFFE)) else $error("pop sp");
  const_b_a: assert property (i_src_sel == 4'h3 && !i_src_byte |->
    o_src_is_const && o_src_data == (m == 2'b11 ? 16'hFFFF : {14'h0000, m}))
    else $error("const b");
  const_a_a: assert property (i_src_sel == 4'h2 && m != 2'b00 |->
    o_src_is_const && o_src_data == (m == 2'b01 ? 16'h0000 :
    m == 2'b10 ? 16'h0004 : 16'h0008)) else $error("const a");
  status_rd_a: assert property (i_src_sel == 4'h2 && m == 2'b00 &&
    !i_src_byte |-> !o_src_is_const && o_src_data == o_status_word)
    else $error("status read");
  ctrl_bits_a: assert property (o_core_halt == o_status_word[4] &&
    o_subsystem_clock_stop == o_status_word[7]) else $error("ctrl bits");
  irq_wake_a: assert property (i_irq_entry |=> !o_core_halt &&
    !o_subsystem_clock_stop && !o_status_word[5]) else $error("irq entry");
  neg_flag_a: assert property (i_flag_upd |=>
    o_status_word[2] == $past(n_bit)) else $error("neg flag");
endmodule // cpu_register_file_props
bind cpu_register_file cpu_register_file_props chk (.*);
`default_nettype wire

// ### tb/tb_cpu_register_file.sv
// Self-checking bench for the core register file
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_cpu_register_file;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_srst, i_src_byte, i_wr_en, i_wr_byte, i_pc_adv, i_push;
  logic i_pop, i_pop_to_sp, i_flag_upd, i_flag_byte, i_flag_is_sub;
  logic i_flag_has_v, i_carry_out, i_irq_entry, i_dco_in_use, i_lfxt_in_use;
  logic o_src_is_const, o_global_irq_enable, o_core_halt;
  logic o_subsystem_clock_stop, o_osc_bias_off, o_lf_crystal_off;
  logic [3:0] i_src_sel, i_dst_sel, i_wr_sel;
  logic [1:0] i_source_mode_bits, i_pc_words;
  logic [15:0] i_wr_data, i_pop_data, i_op_a, i_op_b, i_result, o_src_data;
  logic [15:0] o_dst_data, o_program_counter, o_stack_pointer;
  logic [15:0] o_status_word, o_push_addr;
  int errors = 0;
  int checks = 0;
  cpu_register_file dut (.*);
  exec_unit_model alu (.i_byte(i_flag_byte), .i_sub(i_flag_is_sub),
    .i_a(i_op_a), .i_b(i_op_b), .o_res(i_result), .o_carry(i_carry_out));
  initial begin
    i_clk = 0;
    forever #2 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Strobes are pulses: drop them at the edge that takes them
  task automatic tick;
    @(posedge i_clk);
    {i_wr_en, i_pc_adv, i_push, i_pop, i_pop_to_sp, i_flag_upd,
     i_irq_entry} <= '0;
    #1;
  endtask
  task automatic wr(input logic [3:0] s, input logic [15:0] d, input logic b);
    @(posedge i_clk);
    {i_wr_en, i_wr_sel, i_wr_data, i_wr_byte} <= {1'b1, s, d, b};
    tick();
  endtask
  task automatic rd(input logic [3:0] s, input logic [15:0] e);
    @(posedge i_clk);
    i_dst_sel <= s;
    #1 `CHK(o_dst_data, e);
  endtask
  task automatic src(input logic [3:0] s, input logic [1:0] md,
                     input logic [15:0] e);
    @(posedge i_clk);
    {i_src_sel, i_source_mode_bits} <= {s, md};
    #1 `CHK(o_src_data, e);
  endtask
  task automatic fl(input logic b, input logic s, input logic [15:0] a, bb, e);
    @(posedge i_clk);
    {i_flag_upd, i_flag_byte, i_flag_is_sub, i_op_a, i_op_b}
      <= {1'b1, b, s, a, bb};
    tick();
    `CHK(o_status_word & 16'h0107, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {i_srst, i_src_byte, i_wr_en, i_wr_byte, i_pc_adv, i_push, i_pop,
     i_pop_to_sp, i_flag_upd, i_flag_byte, i_flag_is_sub, i_irq_entry,
     i_dco_in_use, i_lfxt_in_use, i_src_sel, i_dst_sel, i_wr_sel,
     i_source_mode_bits, i_pc_words, i_wr_data, i_pop_data, i_op_a,
     i_op_b} = '0;
    i_srst = 1;
    i_flag_has_v = 1;
    repeat (2) @(posedge i_clk);
    i_srst <= 0;
    for (int i = 0; i < 16; i++) rd(i[3:0], 16'h0000);
    wr(4'h0, 16'h1235, 0);
    `CHK(o_program_counter, 16'h1234);
    for (int w = 1; w < 4; w++) begin
      @(posedge i_clk);
      {i_pc_adv, i_pc_words} <= {1'b1, w[1:0]};
      tick();
      `CHK(o_program_counter, 16'h1234 + 16'(w * (w + 1)));
    end
    wr(4'hF, 16'hA5C3, 0);
    rd(4'hF, 16'hA5C3);
    wr(4'h5, 16'hABCD, 1);
    rd(4'h5, 16'h00CD);
    wr(4'h3, 16'h1234, 0);
    src(4'h3, 2'b00, 16'h0000);
    $display("test registers done");
    wr(4'h1, 16'h0401, 0);
    `CHK(o_push_addr, 16'h03FE);
    @(posedge i_clk);
    i_push <= 1;
    tick();
    `CHK(o_stack_pointer, 16'h03FE);
    @(posedge i_clk);
    i_pop <= 1;
    tick();
    `CHK(o_stack_pointer, 16'h0400);
    @(posedge i_clk);
    {i_pop, i_pop_to_sp, i_pop_data} <= {2'b11, 16'h0123};
    tick();
    `CHK(o_stack_pointer, 16'h0122);
    $display("test stack done");
    for (int m = 0; m < 4; m++) begin
      src(4'h3, m[1:0], m == 3 ? 16'hFFFF : 16'(m));
      `CHK(o_src_is_const, 1'b1);
      if (m > 0) src(4'h2, m[1:0], 16'(4 * (m - 1)));
    end
    fl(0, 0, 16'h7FFF, 16'h0001, 16'h0104);
    fl(1, 0, 16'h00FF, 16'h0001, 16'h0003);
    fl(0, 1, 16'h8000, 16'h0001, 16'h0101);
    src(4'h2, 2'b00, 16'h0101);
    $display("test constants and flags done");
    i_dco_in_use <= 1;
    wr(4'h2, 16'hFFF8, 0);
    `CHK(o_status_word, 16'h01F8);
    `CHK({o_global_irq_enable, o_core_halt, o_subsystem_clock_stop, o_osc_bias_off, o_lf_crystal_off}, 5'b11101);
    @(posedge i_clk);
    {i_irq_entry, i_dco_in_use} <= 2'b10;
    tick();
    `CHK(o_status_word, 16'h0148);
    `CHK(o_osc_bias_off, 1'b1);
    $display("test power bits done");
    summarize();
  end
  // Whole run is about sixty cycles; this margin only catches a hang
  initial begin
    #20000;
    errors++;
    summarize();
  end
endmodule // tb_cpu_register_file
`default_nettype wire
